// ==== rtl/swtg_defines.vh ====
`ifndef SWTG_DEFINES_VH
`define SWTG_DEFINES_VH

// Register offsets (byte addresses)
`define SWTG_OFS_CTRL   8'h00
`define SWTG_OFS_TDLY   8'h04
`define SWTG_OFS_GDLY   8'h08
`define SWTG_OFS_GLEN   8'h0C
`define SWTG_OFS_VLVL   8'h10
`define SWTG_OFS_NSWP   8'h14
`define SWTG_OFS_CMD    8'h18
`define SWTG_OFS_STAT   8'h1C

// Trigger source codes in CTRL[1:0]
`define SWTG_SRC_FREE   2'h0
`define SWTG_SRC_VIDEO  2'h1
`define SWTG_SRC_EXT    2'h2
`define SWTG_SRC_GATE   2'h3

// CTRL field positions
`define SWTG_CTRL_POL   2
`define SWTG_CTRL_SGL   3
`define SWTG_CTRL_SPAN0 4
`define SWTG_CTRL_GEDIT 5

// Delay fields: step count [6:0], subrange [10:8]
`define SWTG_DLY_RNG_LSB 8
`define SWTG_STEPS_MAX  7'h64
`define SWTG_RANGE_MAX  3'h5
`define SWTG_PCT_MAX    7'h64

// CMD bits
`define SWTG_CMD_GO     0
`define SWTG_CMD_ABORT  1

// Reset values
`define SWTG_RST_CTRL   6'h00
`define SWTG_RST_DLY    11'h000
`define SWTG_RST_PCT    7'h32
`define SWTG_RST_NSWP   10'h001

// Finest delay step and clock period
`define SWTG_STEP_NS    10000
`define SWTG_CLK_NS     10
`define SWTG_STEP_CYC   (`SWTG_STEP_NS / `SWTG_CLK_NS)

`endif

// ==== rtl/swtg_sync_edge.v ====
`timescale 1ns/10ps
module swtg_sync_edge (
    input  wire i_sys_clk,
    input  wire i_resetn,
    input  wire i_pin,
    output reg  o_rise,
    output reg  o_fall
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            o_rise <= sync_q & ~last_q;
            o_fall <= ~sync_q & last_q;
        end
    end
endmodule

// ==== rtl/swtg_delay_timer.v ====
`timescale 1ns/10ps
`include "swtg_defines.vh"
module swtg_delay_timer #(
    parameter P_STEP_CYC = `SWTG_STEP_CYC
) (
    input  wire       i_sys_clk,
    input  wire       i_resetn,
    input  wire       i_load,
    input  wire       i_clear,
    input  wire [6:0] i_steps,
    input  wire [2:0] i_range,
    output reg        o_done
);
    reg  [31:0] pre_q;
    reg  [6:0]  cnt_q;
    reg         busy_q;
    reg  [31:0] lim;

    always @* begin
        case (i_range)
            3'h0:    lim = P_STEP_CYC;
            3'h1:    lim = P_STEP_CYC * 10;
            3'h2:    lim = P_STEP_CYC * 100;
            3'h3:    lim = P_STEP_CYC * 1000;
            3'h4:    lim = P_STEP_CYC * 10000;
            default: lim = P_STEP_CYC * 100000;
        endcase
    end

    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pre_q  <= 32'h00000000;
            cnt_q  <= 7'h00;
            busy_q <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_clear) begin
                busy_q <= 1'b0;
            end else if (i_load) begin
                pre_q <= 32'h00000000;
                cnt_q <= i_steps;
                busy_q <= (i_steps != 7'h00);
                o_done <= (i_steps == 7'h00);
            end else if (busy_q) begin
                if (pre_q == lim - 32'h00000001) begin
                    pre_q <= 32'h00000000;
                    cnt_q <= cnt_q - 7'h01;
                    if (cnt_q == 7'h01) begin
                        busy_q <= 1'b0;
                        o_done <= 1'b1;
                    end
                end else begin
                    pre_q <= pre_q + 32'h00000001;
                end
            end
        end
    end
endmodule

// ==== rtl/swtg_sequencer.v ====
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "swtg_defines.vh"
module swtg_sequencer #(
    parameter P_STEP_CYC = `SWTG_STEP_CYC,
    parameter P_VID_W    = 12
) (
    input  wire               i_sys_clk,
    input  wire               i_resetn,
    input  wire [7:0]         i_addr,
    input  wire [31:0]        i_wdata,
    input  wire               i_wr,
    input  wire               i_rd,
    output reg  [31:0]        o_rdata,
    input  wire               i_ext_trig,
    input  wire [P_VID_W-1:0] i_video,
    input  wire               i_sweep_done,
    output reg                o_sweep_start,
    output reg                o_acquire,
    output reg                o_zero_span,
    output reg                o_armed
);
    localparam S_IDLE  = 7'h01;
    localparam S_ARM   = 7'h02;
    localparam S_TDLY  = 7'h04;
    localparam S_RUN   = 7'h08;
    localparam S_GWAIT = 7'h10;
    localparam S_GDLY  = 7'h20;
    localparam S_GLEN  = 7'h40;

    reg  [5:0]           ctrl_q;
    reg  [10:0]          tdly_q;
    reg  [10:0]          gdly_q;
    reg  [10:0]          glen_q;
    reg  [6:0]           pct_q;
    reg  [9:0]           nswp_q;
    reg  [6:0]           state_q;
    reg  [6:0]           state_d;
    reg  [9:0]           remain_q;
    reg  [9:0]           remain_d;
    reg                  first_q;
    reg                  first_d;
    reg                  acq_d;
    reg                  start_d;
    reg                  ld_t;
    reg                  ld_gd;
    reg                  ld_gl;
    reg                  above_q;
    reg                  go_q;
    reg                  abort_q;
    reg  [10:0]          wr_dly;
    reg  [6:0]           wr_pct;
    reg  [9:0]           wr_nswp;

    wire                 ext_rise;
    wire                 ext_fall;
    wire                 t_done;
    wire                 gd_done;
    wire                 gl_done;
    wire [1:0]           src;
    wire                 pol_fall;
    wire                 single;
    wire                 span0_eff;
    wire                 ext_evt;
    wire                 above;
    wire                 vid_evt;
    wire [P_VID_W+6:0]   vid_x100;
    wire [P_VID_W+6:0]   thr;

    assign src      = ctrl_q[1:0];
    assign pol_fall = ctrl_q[`SWTG_CTRL_POL];
    assign single   = ctrl_q[`SWTG_CTRL_SGL];
    assign span0_eff = ctrl_q[`SWTG_CTRL_SPAN0] | ctrl_q[`SWTG_CTRL_GEDIT];

    assign ext_evt = pol_fall ? ext_fall : ext_rise;

    // Level as percent of full scale
    assign vid_x100 = i_video * 7'h64;
    assign thr      = {pct_q, {P_VID_W{1'b0}}};
    assign above    = vid_x100 > thr;
    assign vid_evt  = above & ~above_q & span0_eff;

    swtg_sync_edge u_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_pin     (i_ext_trig),
        .o_rise    (ext_rise),
        .o_fall    (ext_fall)
    );

    swtg_delay_timer #(
        .P_STEP_CYC (P_STEP_CYC)
    ) u_tdly (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_load    (ld_t),
        .i_clear   (abort_q),
        .i_steps   (tdly_q[6:0]),
        .i_range   (tdly_q[10:8]),
        .o_done    (t_done)
    );

    swtg_delay_timer #(
        .P_STEP_CYC (P_STEP_CYC)
    ) u_gdly (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_load    (ld_gd),
        .i_clear   (abort_q),
        .i_steps   (gdly_q[6:0]),
        .i_range   (gdly_q[10:8]),
        .o_done    (gd_done)
    );

    swtg_delay_timer #(
        .P_STEP_CYC (P_STEP_CYC)
    ) u_glen (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_load    (ld_gl),
        .i_clear   (abort_q),
        .i_steps   (glen_q[6:0]),
        .i_range   (glen_q[10:8]),
        .o_done    (gl_done)
    );

    // Clamping of written delay, level and count
    always @* begin
        wr_dly = {i_wdata[10:8], 1'b0, i_wdata[6:0]};
        if (i_wdata[10:8] > `SWTG_RANGE_MAX) begin
            wr_dly[10:8] = `SWTG_RANGE_MAX;
        end
        if (i_wdata[6:0] > `SWTG_STEPS_MAX) begin
            wr_dly[6:0] = `SWTG_STEPS_MAX;
        end
        wr_pct = i_wdata[6:0];
        if (i_wdata[6:0] > `SWTG_PCT_MAX) begin
            wr_pct = `SWTG_PCT_MAX;
        end
        wr_nswp = i_wdata[9:0];
        if (i_wdata[9:0] == 10'h000) begin
            wr_nswp = 10'h001;
        end
    end

    // Register writes
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q  <= `SWTG_RST_CTRL;
            tdly_q  <= `SWTG_RST_DLY;
            gdly_q  <= `SWTG_RST_DLY;
            glen_q  <= `SWTG_RST_DLY;
            pct_q   <= `SWTG_RST_PCT;
            nswp_q  <= `SWTG_RST_NSWP;
            go_q    <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            go_q    <= 1'b0;
            abort_q <= 1'b0;
            if (i_wr) begin
                case (i_addr)
                    `SWTG_OFS_CTRL: begin
                        ctrl_q  <= i_wdata[5:0];
                        abort_q <= 1'b1;
                    end
                    `SWTG_OFS_TDLY: tdly_q <= wr_dly;
                    `SWTG_OFS_GDLY: gdly_q <= wr_dly;
                    `SWTG_OFS_GLEN: glen_q <= wr_dly;
                    `SWTG_OFS_VLVL: pct_q  <= wr_pct;
                    `SWTG_OFS_NSWP: nswp_q <= wr_nswp;
                    `SWTG_OFS_CMD: begin
                        go_q    <= i_wdata[`SWTG_CMD_GO];
                        abort_q <= i_wdata[`SWTG_CMD_ABORT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Read data, one cycle after the strobe
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `SWTG_OFS_CTRL: o_rdata <= {26'h0000000, ctrl_q};
                `SWTG_OFS_TDLY: o_rdata <= {21'h000000, tdly_q};
                `SWTG_OFS_GDLY: o_rdata <= {21'h000000, gdly_q};
                `SWTG_OFS_GLEN: o_rdata <= {21'h000000, glen_q};
                `SWTG_OFS_VLVL: o_rdata <= {25'h0000000, pct_q};
                `SWTG_OFS_NSWP: o_rdata <= {22'h000000, nswp_q};
                `SWTG_OFS_STAT: o_rdata <= {12'h000, o_acquire, remain_q,
                                            span0_eff, 1'b0, state_q};
                default:        o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // Sweep sequencing
    always @* begin
        state_d  = state_q;
        remain_d = remain_q;
        first_d  = first_q;
        acq_d    = o_acquire;
        start_d  = 1'b0;
        ld_t     = 1'b0;
        ld_gd    = 1'b0;
        ld_gl    = 1'b0;
        case (state_q)
            S_IDLE: begin
                acq_d = 1'b0;
                if (!single) begin
                    state_d = S_ARM;
                end else if (go_q) begin
                    state_d  = S_ARM;
                    remain_d = nswp_q;
                end
            end
            S_ARM: begin
                first_d = 1'b1;
                case (src)
                    `SWTG_SRC_FREE: begin
                        start_d = 1'b1;
                        acq_d   = 1'b1;
                        state_d = S_RUN;
                    end
                    `SWTG_SRC_VIDEO: begin
                        if (vid_evt) begin
                            ld_t    = 1'b1;
                            state_d = S_TDLY;
                        end
                    end
                    `SWTG_SRC_EXT: begin
                        if (ext_evt) begin
                            ld_t    = 1'b1;
                            state_d = S_TDLY;
                        end
                    end
                    default: begin
                        state_d = S_GWAIT;
                    end
                endcase
            end
            S_TDLY: begin
                if (t_done) begin
                    start_d = 1'b1;
                    acq_d   = 1'b1;
                    state_d = S_RUN;
                end
            end
            S_RUN: begin
                if (i_sweep_done) begin
                    acq_d = 1'b0;
                    state_d = S_IDLE;
                end
            end
            S_GWAIT: begin
                acq_d = 1'b0;
                if (ext_evt) begin
                    ld_gd   = 1'b1;
                    state_d = S_GDLY;
                end
            end
            S_GDLY: begin
                if (gd_done) begin
                    ld_gl   = 1'b1;
                    acq_d   = 1'b1;
                    start_d = first_q;
                    first_d = 1'b0;
                    state_d = S_GLEN;
                end
            end
            S_GLEN: begin
                if (i_sweep_done) begin
                    acq_d   = 1'b0;
                    state_d = S_IDLE;
                end else if (gl_done) begin
                    acq_d   = 1'b0;
                    state_d = S_GWAIT;
                end
            end
            default: begin
                acq_d   = 1'b0;
                state_d = S_IDLE;
            end
        endcase
        if (i_sweep_done && (state_q == S_RUN || state_q == S_GLEN)) begin
            if (!single) begin
                state_d = S_ARM;
            end else if (remain_q > 10'h001) begin
                remain_d = remain_q - 10'h001;
                state_d  = S_ARM;
            end else begin
                remain_d = 10'h000;
                state_d  = S_IDLE;
            end
        end
        if (abort_q) begin
            state_d  = S_IDLE;
            acq_d    = 1'b0;
            start_d  = 1'b0;
            remain_d = 10'h000;
        end
    end

    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q       <= S_IDLE;
            remain_q      <= 10'h000;
            first_q       <= 1'b0;
            above_q       <= 1'b0;
            o_sweep_start <= 1'b0;
            o_acquire     <= 1'b0;
            o_zero_span   <= 1'b0;
            o_armed       <= 1'b0;
        end else begin
            state_q       <= state_d;
            remain_q      <= remain_d;
            first_q       <= first_d;
            above_q       <= above;
            o_sweep_start <= start_d;
            o_acquire     <= acq_d;
            o_zero_span   <= span0_eff;
            o_armed       <= (state_d != S_IDLE);
        end
    end
endmodule

// ==== verification/swtg_far_side.sv ====
`timescale 1ns/10ps
module swtg_far_side (
    input  wire        i_sys_clk,
    input  wire        i_resetn,
    input  wire        i_gate_req,
    input  wire [15:0] i_gate_w,
    input  wire        i_pol,
    input  wire [15:0] i_sw_len,
    input  wire        i_sweep_start,
    input  wire        i_acquire,
    output wire        o_pin,
    output reg         o_sweep_done
);
    reg  [15:0] gate_cnt_q;
    reg  [15:0] pos_q;
    wire [15:0] pos_d;

    // Pin rests at the idle level of the chosen polarity
    assign o_pin = i_pol ^ (gate_cnt_q != 16'h0000);
    assign pos_d = (i_sweep_start ? 16'h0000 : pos_q) + {15'h0000, i_acquire};

    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gate_cnt_q   <= 16'h0000;
            pos_q        <= 16'h0000;
            o_sweep_done <= 1'b0;
        end else begin
            o_sweep_done <= 1'b0;
            if (i_gate_req) begin
                gate_cnt_q <= i_gate_w;
            end else if (gate_cnt_q != 16'h0000) begin
                gate_cnt_q <= gate_cnt_q - 16'h0001;
            end
            // Sweep position only advances while acquiring
            if (i_acquire && pos_d == i_sw_len) begin
                o_sweep_done <= 1'b1;
                pos_q        <= 16'h0000;
            end else begin
                pos_q <= pos_d;
            end
        end
    end
endmodule

// ==== verification/swtg_sequencer_props.sv ====
`timescale 1ns/10ps
module swtg_seq_props (
    input wire        i_sys_clk,
    input wire        i_resetn,
    input wire [7:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire        i_wr,
    input wire        i_ext_trig,
    input wire        i_sweep_done,
    input wire        o_sweep_start,
    input wire        o_acquire,
    input wire        o_zero_span,
    input wire        o_armed
);
    reg [5:0] ctrl_q;
    reg       tdly0_q;
    reg [2:0] age_q;

    // Shadow of control and cycles since its last write
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q  <= 6'h00;
            tdly0_q <= 1'b1;
            age_q   <= 3'h7;
        end else begin
            if (i_wr && i_addr == 8'h00) begin
                ctrl_q <= i_wdata[5:0];
                age_q  <= 3'h0;
            end else if (age_q != 3'h7) begin
                age_q <= age_q + 3'h1;
            end
            if (i_wr && i_addr == 8'h04) begin
                tdly0_q <= (i_wdata[6:0] == 7'h00);
            end
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_done_free;
        age_q == 3'h7 && ctrl_q[3:0] == 4'h0 && o_acquire && i_sweep_done;
    endsequence
    sequence s_ext_edge;
        age_q == 3'h7 && ctrl_q[1:0] == 2'h2 && tdly0_q && o_armed && !o_acquire
            && (ctrl_q[2] ? $fell(i_ext_trig) : $rose(i_ext_trig));
    endsequence

    chk_start_one_cyc: assert property (o_sweep_start |=> !o_sweep_start)
        else $error("start pulse longer than one cycle");
    chk_start_acquire: assert property (o_sweep_start |-> o_acquire && o_armed)
        else $error("start without acquire");
    chk_acq_armed: assert property (o_acquire |-> o_armed)
        else $error("acquire while idle");
    chk_done_drops_acq: assert property (o_acquire && i_sweep_done |=> !o_acquire)
        else $error("acquire held after sweep end");
    chk_free_restart: assert property (s_done_free |-> ##[1:4] (o_sweep_start || age_q != 3'h7))
        else $error("free run did not restart");
    chk_ext_start: assert property (s_ext_edge |-> ##[3:7] (o_sweep_start || age_q != 3'h7))
        else $error("edge did not start sweep");
    chk_ext_sync_lag: assert property (s_ext_edge |-> !o_sweep_start [*3])
        else $error("start before synchroniser delay");
    chk_video_freq: assert property (age_q == 3'h7 && ctrl_q[1:0] == 2'h1 && ctrl_q[5:4] == 2'h0
        |-> !o_sweep_start && !o_acquire)
        else $error("video start outside zero span");
    chk_zero_span_eff: assert property (age_q == 3'h7 |-> o_zero_span == (ctrl_q[4] | ctrl_q[5]))
        else $error("zero span flag wrong");
endmodule

// ==== verification/test_sweep_trigger_gate_sequencer.sv ====
`timescale 1ns/10ps
module test_sweep_trigger_gate_sequencer;
    localparam integer STEP = 2;
    reg         i_sys_clk = 1'b0;
    reg         i_resetn  = 1'b0;
    reg  [7:0]  i_addr    = 8'h00;
    reg  [31:0] i_wdata   = 32'h0;
    reg         i_wr      = 1'b0;
    reg         i_rd      = 1'b0;
    reg  [11:0] i_video   = 12'h000;
    reg         gate_req  = 1'b0;
    reg         pol       = 1'b0;
    reg  [15:0] sw_len    = 16'h0014;
    wire [31:0] o_rdata;
    wire        i_ext_trig;
    wire        i_sweep_done;
    wire        o_sweep_start;
    wire        o_acquire;
    wire        o_zero_span;
    wire        o_armed;
    integer     seed = 32'hCF19;
    integer     n_fail = 0;
    integer     samples_checked = 0;
    integer     n, k, n_st, n_acq;
    reg  [31:0] rv, e;
    reg  [7:0]  a;
    reg  [11:0] tbl;

    swtg_sequencer #(.P_STEP_CYC(STEP), .P_VID_W(12)) u_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ext_trig(i_ext_trig), .i_video(i_video), .i_sweep_done(i_sweep_done),
        .o_sweep_start(o_sweep_start), .o_acquire(o_acquire), .o_zero_span(o_zero_span), .o_armed(o_armed));
    swtg_far_side u_far (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_gate_req(gate_req),
        .i_gate_w(16'h0004), .i_pol(pol), .i_sw_len(sw_len), .i_sweep_start(o_sweep_start),
        .i_acquire(o_acquire), .o_pin(i_ext_trig), .o_sweep_done(i_sweep_done));

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task chk(input string name, input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] ad, input [31:0] d);
        begin
            @(posedge i_sys_clk);
            i_addr  <= ad;
            i_wdata <= d;
            i_wr    <= 1'b1;
            @(posedge i_sys_clk);
            i_wr    <= 1'b0;
        end
    endtask
    task rd(input [7:0] ad, output [31:0] d);
        begin
            @(posedge i_sys_clk);
            i_addr <= ad;
            i_rd   <= 1'b1;
            @(posedge i_sys_clk);
            i_rd   <= 1'b0;
            #1 d = o_rdata;
        end
    endtask
    task scan(input integer cyc);
        repeat (cyc) begin
            @(posedge i_sys_clk);
            #1;
            if (o_sweep_start === 1'b1) n_st = n_st + 1;
            if (o_acquire === 1'b1) n_acq = n_acq + 1;
        end
    endtask
    task wait_hi(input sel, input integer lim, output integer c);
        begin
            c = 0;
            while (((sel ? o_acquire : o_sweep_start) !== 1'b1) && c < lim) begin
                @(posedge i_sys_clk);
                #1;
                c = c + 1;
            end
        end
    endtask
    task fire;
        begin
            @(posedge i_sys_clk);
            gate_req <= 1'b1;
            @(posedge i_sys_clk);
            gate_req <= 1'b0;
            #1;
        end
    endtask
    function [31:0] dcyc(input [10:0] v);
        dcyc = v[6:0] * STEP * (10 ** v[10:8]);
    endfunction
    function [31:0] win(input integer v, input integer lo, input integer hi);
        win = (v >= lo && v <= hi) ? 32'h1 : 32'h0;
    endfunction
    task final_report;
        begin
            $display("checked %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask

    initial begin
        #200000;
        n_fail = n_fail + 1;
        final_report;
    end

    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        rd(8'h10, rv);
        chk("level_rst", rv, 32'h32);
        wr(8'h10, 32'h7F);
        rd(8'h10, rv);
        chk("level_clamp", rv, 32'h64);
        rd(8'h20, rv);
        chk("unmapped", rv, 32'h0);
        for (k = 0; k < 3; k = k + 1) begin
            a = 8'h04 + {k[5:0], 2'b00};
            wr(a, 32'h7FF);
            rd(a, rv);
            chk("dly_clamp", rv, 32'h564);
            rv = $random(seed);
            e = {21'h0, {1'b0, rv[9:8]} + {2'b00, rv[10]}, 1'b0, rv[6:0] % 7'h65};
            wr(a, e);
            rd(a, rv);
            chk("dly_field", rv, e);
        end
        wr(8'h14, 32'h0);
        rd(8'h14, rv);
        chk("count_min", rv, 32'h1);
        n_st = 0;
        scan(230);
        chk("free_starts", win(n_st, 8, 12), 32'h1);
        wr(8'h14, 32'h3);
        wr(8'h00, 32'h8);
        for (k = 0; k < 2; k = k + 1) begin
            n_st = 0;
            wr(8'h18, 32'h1);
            scan(200);
            chk("single_cnt", n_st, 32'h3);
            chk("single_idle", {31'h0, o_armed}, 32'h0);
        end
        wr(8'h18, 32'h1);
        scan(5);
        rd(8'h1C, rv);
        chk("stat_run", rv, 32'h00080608);
        wr(8'h18, 32'h2);
        rd(8'h1C, rv);
        chk("stat_abort", rv, 32'h1);
        chk("abort_idle", {31'h0, o_armed}, 32'h0);
        for (k = 0; k < 4; k = k + 1) begin
            rv = $random(seed);
            e = (k < 2) ? 32'h0 : {25'h0, rv[6:0] % 7'h33};
            wr(8'h04, e);
            pol <= k[0];
            repeat (5) @(posedge i_sys_clk);
            wr(8'h00, {29'h0, k[0], 2'h2});
            repeat (5) @(posedge i_sys_clk);
            fire;
            wait_hi(1'b0, 2000, n);
            chk("ext_delay", win(n, dcyc(e[10:0]) + 3, dcyc(e[10:0]) + 8), 32'h1);
            repeat (40) @(posedge i_sys_clk);
        end
        pol <= 1'b0;
        wr(8'h10, 32'h32);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        repeat (10) @(posedge i_sys_clk);
        i_video <= 12'hFFF;
        n_st = 0;
        scan(50);
        chk("video_freq", n_st, 32'h0);
        @(posedge i_sys_clk);
        i_video <= 12'h000;
        wr(8'h00, 32'h11);
        repeat (10) @(posedge i_sys_clk);
        repeat (30) begin
            @(posedge i_sys_clk);
            rv = $random(seed);
            i_video <= rv[11:0] % 12'h801;
            scan(1);
        end
        @(posedge i_sys_clk);
        i_video <= 12'h800;
        scan(5);
        chk("video_below", n_st, 32'h0);
        @(posedge i_sys_clk);
        i_video <= 12'h801;
        #1;
        wait_hi(1'b0, 40, n);
        chk("video_start", win(n, 1, 8), 32'h1);
        wr(8'h08, 32'h3);
        wr(8'h0C, 32'h105);
        sw_len <= 16'h0096;
        for (k = 0; k < 2; k = k + 1) begin
            wr(8'h00, {27'h0, k[0], 4'h3});
            repeat (5) @(posedge i_sys_clk);
            fire;
            wait_hi(1'b1, 200, n);
            chk("gate_delay", win(n, 9, 14), 32'h1);
            n_st = (o_sweep_start === 1'b1) ? 1 : 0;
            n_acq = 1;
            scan(300);
            chk("gate_len", win(n_acq, 99, 102), 32'h1);
            fire;
            scan(300);
            chk("gate_total", win(n_acq, 150, 152), 32'h1);
            chk("gate_starts", n_st, 32'h1);
        end
        tbl = 12'b01_11_01_00_10_00;
        for (k = 0; k < 6; k = k + 1) begin
            wr(8'h00, {26'h0, tbl[k*2 +: 2], 4'h0});
            repeat (3) @(posedge i_sys_clk);
            #1;
            chk("zero_span", {31'h0, o_zero_span}, {31'h0, |tbl[k*2 +: 2]});
        end
        final_report;
    end
endmodule

bind swtg_sequencer swtg_seq_props u_props (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_ext_trig(i_ext_trig), .i_sweep_done(i_sweep_done),
    .o_sweep_start(o_sweep_start), .o_acquire(o_acquire), .o_zero_span(o_zero_span), .o_armed(o_armed));
